// ### core/sfpa_array.sv
module sfpa_array
    import sfpa_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W
) (
    input  wire logic          clock,
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic          nv_we,
    input  wire logic [1:0]    nv_din,
    output logic      [1:0]    nv_bp
);
    logic [DW-1:0] cells [2**AW];
    // block protect cells model nonvolatile storage: no reset touches them
    logic [1:0]    nv_cells = BP_RESET;

    assign nv_bp = nv_cells;

    always_ff @(posedge clock) begin
        if (rd_en) begin
            rd_data <= cells[rd_addr];
        end
        if (wr_en) begin
            cells[wr_addr] <= wr_data;
        end
        if (nv_we) begin
            nv_cells <= nv_din;
        end
    end
endmodule

// ### core/sfpa_core.sv
// Behaviour
// - status write refused when pin protect enable is 1 and protect pin low.
// - status byte: enable bit7, block bits 3..2, latch bit1, bit6 one, rest zero.
// - block protect bits kept in storage untouched by reset.
// - status write clears latch; only the set command sets it.
// - block bits 01 protect C000-FFFF, 10 protect 8000-FFFF, 11 everything.
// - array write needs latch set and unprotected address; pin alone never blocks.
// - write is opcode, 16-bit address msb first, then data bytes.
// - each byte committed after its eighth bit; no length limit.
// - address increments after each byte, wrapping FFFF to 0000.
// - chip select rise ends write; partial byte dropped.
// - protect pin level captured only at chip select fall.
// - after read address input ignored; data shifted out msb first.
// - chip select rise ends read and releases output.
// - fast read skips one dummy byte, then behaves as read.
// - pause low with clock low freezes transfer; high with clock low resumes.
// - opcodes 06,04,05,01,03,02 (and 0B) decoded.
// - latch cleared when a memory or status write completes.
// - input sampled on rising clock edge, output changed on falling edge.
// - one opcode per chip select frame.
module sfpa_core
    import sfpa_pkg::*;
(
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic sclk,
    input  wire logic cs_n,
    input  wire logic mosi,
    input  wire logic hold_n,
    input  wire logic wp_n,
    output logic      miso,
    output logic      miso_oe
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic is_protected(input logic [1:0] bp, input logic [15:0] a);
        case (bp)
            2'h1:    is_protected = (a >= PROT_QUARTER_BASE);
            2'h2:    is_protected = (a >= PROT_HALF_BASE);
            2'h3:    is_protected = 1'b1;
            default: is_protected = 1'b0;
        endcase
    endfunction

    function automatic logic [7:0] status_byte(input logic pin_protect_enable, input logic [1:0] bp,
                                               input logic write_enable_latch);
        logic [7:0] s;
        s = STAT_FIXED_VALUE;
        s[STAT_PIN_PROTECT_EN] = pin_protect_enable;
        s[STAT_BLOCK_HI]       = bp[1];
        s[STAT_BLOCK_LO]       = bp[0];
        s[STAT_WRITE_LATCH]    = write_enable_latch;
        status_byte = s;
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [2:0]  s_sclk;
        logic [2:0]  s_cs;
        logic [2:0]  s_mosi;
        logic [2:0]  s_hold;
        logic [2:0]  s_wp;
        sfpa_state_t st;
        logic [3:0]  cnt;
        logic [7:0]  sh;
        logic [7:0]  op;
        logic [15:0] addr;
        logic [7:0]  osh;
        logic        write_enable_latch;
        logic        pin_protect_enable;
        logic        wp_lat;
        logic        hold;
        logic        drv;
        logic        miso;
        logic        oe;
        logic        fetch;
        logic        load;
        logic        pend;
        logic [23:0] pend_data;
        logic        nv_we;
        logic [1:0]  nv_din;
    } sfpa_core_t;

    localparam sfpa_core_t CORE_RESET = '{
        s_sclk: SYNC_IDLE_LO, s_cs: SYNC_IDLE_HI, s_mosi: SYNC_IDLE_LO,
        s_hold: SYNC_IDLE_HI, s_wp: SYNC_IDLE_HI, st: ST_OPCODE,
        cnt: '0, sh: '0, op: '0, addr: '0, osh: '0,
        write_enable_latch: WEL_RESET, pin_protect_enable: PIN_PROTECT_ENABLE_RESET, wp_lat: 1'b1, hold: 1'b0,
        drv: 1'b0, miso: 1'b0, oe: 1'b0, fetch: 1'b0, load: 1'b0,
        pend: 1'b0, pend_data: '0, nv_we: 1'b0, nv_din: BP_RESET
    };

    sfpa_core_t        r_reg;
    sfpa_core_t        r_next;
    logic              sclk_rise;
    logic              sclk_fall;
    logic              cs_fall;
    logic              cs_rise;
    logic              active;
    logic              byte_end;
    logic [7:0]        byte_in;
    logic [1:0]        bp;
    logic [7:0]        rd_data;
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic [23:0]       fifo_out_data;
    logic              fifo_out_ready;

    // ----------------------------------------
    // edges from synchronised pins
    // ----------------------------------------
    // stage 0 of each synchroniser feeds only stage 1, except chip select stage 0, which also gates output enable
    assign sclk_rise = r_reg.s_sclk[1] && !r_reg.s_sclk[2];
    assign sclk_fall = !r_reg.s_sclk[1] && r_reg.s_sclk[2];
    assign cs_fall   = !r_reg.s_cs[1] && r_reg.s_cs[2];
    assign cs_rise   = r_reg.s_cs[1] && !r_reg.s_cs[2];
    assign active    = !r_reg.s_cs[1];
    assign byte_end  = (r_reg.cnt[2:0] == BYTE_LAST_BIT);
    assign byte_in   = {r_reg.sh[6:0], r_reg.s_mosi[1]};

    always_comb begin
        r_next        = r_reg;
        r_next.s_sclk = {r_reg.s_sclk[1:0], sclk};
        r_next.s_cs   = {r_reg.s_cs[1:0], cs_n};
        r_next.s_mosi = {r_reg.s_mosi[1:0], mosi};
        r_next.s_hold = {r_reg.s_hold[1:0], hold_n};
        r_next.s_wp   = {r_reg.s_wp[1:0], wp_n};
        r_next.fetch  = 1'b0;
        r_next.nv_we  = 1'b0;
        r_next.load   = r_reg.fetch;
        if (r_reg.load) begin
            r_next.osh = rd_data;
        end
        if (r_reg.pend && fifo_in_ready) begin
            r_next.pend = 1'b0;
        end
        // pause sampled only with clock low
        if (!r_reg.s_sclk[1]) begin
            r_next.hold = !r_reg.s_hold[1];
        end
        if (cs_fall) begin
            r_next.wp_lat = r_reg.s_wp[1];
        end
        if (cs_rise) begin
            r_next.st  = ST_OPCODE;
            r_next.cnt = '0;
            r_next.op  = '0;
            r_next.drv = 1'b0;
            // latch set only by its command; cleared by clear command or write frame end
            if (r_reg.op == OP_SET_LATCH) begin
                r_next.write_enable_latch = 1'b1;
            end
            if (r_reg.op == OP_CLR_LATCH || r_reg.op == OP_WRITE) begin
                r_next.write_enable_latch = 1'b0;
            end
        end else if (active && !r_reg.hold && sclk_rise) begin
            r_next.sh  = byte_in;
            r_next.cnt = r_reg.cnt + 4'h1;
            case (r_reg.st)
                ST_OPCODE: begin
                    if (byte_end) begin
                        r_next.cnt = '0;
                        r_next.op  = byte_in;
                        case (byte_in)
                            OP_STAT_RD: begin
                                r_next.st  = ST_STAT_RD;
                                r_next.osh = status_byte(r_reg.pin_protect_enable, bp, r_reg.write_enable_latch);
                            end
                            OP_STAT_WR: r_next.st = ST_STAT_WR;
                            OP_READ, OP_FAST_READ, OP_WRITE: r_next.st = ST_ADDR;
                            // rest of the frame ignored; unknown too
                            default: r_next.st = ST_WAIT;
                        endcase
                    end
                end
                ST_ADDR: begin
                    r_next.addr = {r_reg.addr[14:0], r_reg.s_mosi[1]};
                    if (r_reg.cnt == ADDR_LAST_BIT) begin
                        r_next.cnt = '0;
                        if (r_reg.op == OP_WRITE) begin
                            r_next.st = ST_WDATA;
                        end else if (r_reg.op == OP_FAST_READ) begin
                            r_next.st = ST_DUMMY;
                        end else begin
                            r_next.st    = ST_RDATA;
                            r_next.fetch = 1'b1;
                        end
                    end
                end
                ST_DUMMY: begin
                    if (byte_end) begin
                        r_next.cnt   = '0;
                        r_next.st    = ST_RDATA;
                        r_next.fetch = 1'b1;
                    end
                end
                ST_WDATA: begin
                    if (byte_end) begin
                        r_next.cnt  = '0;
                        r_next.addr = r_reg.addr + 16'h1;
                        // latch and block gate; ranges; queue for commit
                        if (r_reg.write_enable_latch && !is_protected(bp, r_reg.addr)) begin
                            r_next.pend      = 1'b1;
                            r_next.pend_data = {r_reg.addr, byte_in};
                        end
                    end
                end
                ST_STAT_WR: begin
                    if (byte_end) begin
                        r_next.st  = ST_WAIT;
                        r_next.write_enable_latch = 1'b0;
                        if (r_reg.write_enable_latch && !(r_reg.pin_protect_enable && !r_reg.wp_lat)) begin
                            r_next.pin_protect_enable   = byte_in[STAT_PIN_PROTECT_EN];
                            r_next.nv_we  = 1'b1;
                            r_next.nv_din = byte_in[STAT_BLOCK_HI:STAT_BLOCK_LO];
                        end
                    end
                end
                ST_RDATA: begin
                    if (byte_end) begin
                        r_next.cnt   = '0;
                        r_next.addr  = r_reg.addr + 16'h1;
                        r_next.fetch = 1'b1;
                    end
                end
                ST_STAT_RD: begin
                    if (byte_end) begin
                        r_next.cnt = '0;
                        r_next.osh = status_byte(r_reg.pin_protect_enable, bp, r_reg.write_enable_latch);
                    end
                end
                ST_WAIT: r_next.cnt = '0;
                default: r_next.st = ST_WAIT;
            endcase
        end else if (active && !r_reg.hold && sclk_fall) begin
            if (r_reg.st == ST_RDATA || r_reg.st == ST_STAT_RD) begin
                r_next.miso = r_reg.osh[7];
                r_next.osh  = {r_reg.osh[6:0], 1'b0};
                r_next.drv  = 1'b1;
            end
        end
        // released outside a frame and during pause
        r_next.oe = r_next.drv && !r_next.hold && !r_next.s_cs[1];
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            r_reg <= CORE_RESET;
        end else begin
            r_reg <= r_next;
        end
    end
    assign miso           = r_reg.miso;
    assign miso_oe        = r_reg.oe;
    // reads win the single array port; writes wait in the fifo
    assign fifo_out_ready = !r_reg.fetch;

    sfpa_fifo #(
        .WIDTH(24),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock    (clock),
        .rstn     (rstn),
        .in_valid (r_reg.pend),
        .in_ready (fifo_in_ready),
        .in_data  (r_reg.pend_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data (fifo_out_data)
    );
    sfpa_array #(
        .AW(ADDR_W),
        .DW(DATA_W)
    ) u_array (
        .clock  (clock),
        .rd_en  (r_reg.fetch),
        .rd_addr(r_reg.addr),
        .rd_data(rd_data),
        .wr_en  (fifo_out_valid && fifo_out_ready),
        .wr_addr(fifo_out_data[23:8]),
        .wr_data(fifo_out_data[7:0]),
        .nv_we  (r_reg.nv_we),
        .nv_din (r_reg.nv_din),
        .nv_bp  (bp)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    cs_release_a: assert property (@(posedge clock) disable iff (!rstn)
        cs_rise |=> !miso_oe) else $error("output driven after chip select rise");
    hold_quiet_a: assert property (@(posedge clock) disable iff (!rstn)
        r_reg.hold && r_reg.s_sclk[1] && sclk_rise |=> $stable(r_reg.cnt) && !miso_oe)
        else $error("transfer moved during pause");
    stat_guard_a: assert property (@(posedge clock) disable iff (!rstn)
        r_reg.nv_we |-> $past(r_reg.write_enable_latch) && !($past(r_reg.pin_protect_enable) && !$past(r_reg.wp_lat)))
        else $error("status write accepted while guarded");
    push_guard_a: assert property (@(posedge clock) disable iff (!rstn)
        $rose(r_reg.pend) |-> $past(r_reg.write_enable_latch) && !is_protected($past(bp), $past(r_reg.addr)))
        else $error("array write queued while blocked");
    latch_set_a: assert property (@(posedge clock) disable iff (!rstn)
        $rose(r_reg.write_enable_latch) |-> $past(cs_rise) && $past(r_reg.op) == OP_SET_LATCH)
        else $error("latch set without its command");
    wp_capture_a: assert property (@(posedge clock) disable iff (!rstn)
        !cs_fall |=> $stable(r_reg.wp_lat)) else $error("protect pin taken mid frame");
    addr_wrap_a: assert property (@(posedge clock) disable iff (!rstn)
        r_reg.st == ST_RDATA && active && !r_reg.hold && sclk_rise && byte_end
        && !cs_rise && r_reg.addr == 16'hFFFF |=> r_reg.addr == 16'h0000 ##1 r_reg.load)
        else $error("address did not wrap");
    read_load_a: assert property (@(posedge clock) disable iff (!rstn)
        r_reg.fetch |=> r_reg.load ##1 (r_reg.osh == $past(rd_data)))
        else $error("read data not loaded");
    bad_op_a: assert property (@(posedge clock) disable iff (!rstn)
        r_reg.st == ST_WAIT && !cs_rise |=> r_reg.st == ST_WAIT && !r_reg.drv)
        else $error("left idle before frame end");
    write_commit_c: cover property (@(posedge clock) disable iff (!rstn)
        fifo_out_valid && fifo_out_ready);
    stat_read_c: cover property (@(posedge clock) disable iff (!rstn)
        r_reg.st == ST_STAT_RD && miso_oe);
    fast_read_c: cover property (@(posedge clock) disable iff (!rstn)
        r_reg.st == ST_DUMMY ##[1:400] r_reg.load);
    pause_c: cover property (@(posedge clock) disable iff (!rstn) $rose(r_reg.hold));
endmodule

// ### core/sfpa_fifo.sv
module sfpa_fifo
    import sfpa_pkg::*;
#(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4
) (
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [PW:0]   count;
    } sfpa_fifo_t;

    sfpa_fifo_t             q_reg;
    sfpa_fifo_t             q_next;
    logic       [WIDTH-1:0] slots [DEPTH];
    logic                   push;
    logic                   pop;

    assign in_ready  = (q_reg.count != (PW+1)'(DEPTH));
    assign out_valid = (q_reg.count != '0);
    assign out_data  = slots[q_reg.rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        q_next = q_reg;
        if (push) begin
            q_next.wr_ptr = (q_reg.wr_ptr == PW'(DEPTH - 1)) ? '0 : q_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            q_next.rd_ptr = (q_reg.rd_ptr == PW'(DEPTH - 1)) ? '0 : q_reg.rd_ptr + 1'b1;
        end
        q_next.count = q_reg.count + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    // storage carries no reset; only pointers matter
    always_ff @(posedge clock) begin
        if (push) begin
            slots[q_reg.wr_ptr] <= in_data;
        end
    end
endmodule

// ### inc/sfpa_pkg.sv
package sfpa_pkg;

    // ----------------------------------------
    // opcodes
    // ----------------------------------------
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH = 8'h04;
    localparam logic [7:0] OP_STAT_RD   = 8'h05;
    localparam logic [7:0] OP_STAT_WR   = 8'h01;
    localparam logic [7:0] OP_READ      = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_WRITE     = 8'h02;

    // ----------------------------------------
    // protection_status layout
    // ----------------------------------------
    localparam int         STAT_PIN_PROTECT_EN = 7;
    localparam int         STAT_FIXED_ONE      = 6;
    localparam int         STAT_BLOCK_HI       = 3;
    localparam int         STAT_BLOCK_LO       = 2;
    localparam int         STAT_WRITE_LATCH    = 1;
    localparam logic [7:0] STAT_FIXED_VALUE    = 8'h40;
    localparam logic       WEL_RESET           = 1'b0;
    localparam logic       PIN_PROTECT_ENABLE_RESET          = 1'b0;
    localparam logic [1:0] BP_RESET            = 2'h0;

    // ----------------------------------------
    // block protect boundaries
    // ----------------------------------------
    localparam logic [15:0] PROT_QUARTER_BASE = 16'hC000;
    localparam logic [15:0] PROT_HALF_BASE    = 16'h8000;

    // ----------------------------------------
    // framing
    // ----------------------------------------
    localparam int         ADDR_W       = 16;
    localparam int         DATA_W       = 8;
    localparam int         FIFO_DEPTH   = 4;
    localparam logic [3:0] ADDR_LAST_BIT = 4'hF;
    localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
    localparam logic [2:0] SYNC_IDLE_HI  = 3'h7;
    localparam logic [2:0] SYNC_IDLE_LO  = 3'h0;

    typedef enum logic [2:0] {
        ST_OPCODE,
        ST_ADDR,
        ST_DUMMY,
        ST_WDATA,
        ST_RDATA,
        ST_STAT_RD,
        ST_STAT_WR,
        ST_WAIT
    } sfpa_state_t;

endpackage

// ### tb/sfpa_core_tb.sv
module sfpa_core_tb
    import sfpa_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic       clock, rstn, sclk, cs_n, mosi, hold_n, wp_n, miso, miso_oe;
    logic [7:0] rx;
    logic [7:0] mem_m [int];
    logic       en_m, wel_m, wp_m;
    logic [1:0] bp_m;
    logic [15:0] addrs [3] = '{16'h7FFF, 16'hBFFF, 16'hC000};
    int         fail_count, total_checks;

    always #2 clock = ~clock;

    sfpa_core dut_u (.clock(clock), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .hold_n(hold_n), .wp_n(wp_n), .miso(miso), .miso_oe(miso_oe));
    sfpa_host host_u (.clock(clock), .miso(miso), .miso_oe(miso_oe), .sclk(sclk),
        .cs_n(cs_n), .mosi(mosi), .hold_n(hold_n), .wp_n(wp_n));

    // ----------------------------------------
    // model and checks
    // ----------------------------------------
    function automatic logic [7:0] stat_m();
        return {en_m, 1'b1, 2'h0, bp_m, wel_m, 1'b0};
    endfunction

    function automatic logic prot_m(input logic [15:0] a);
        return bp_m == 2'h3 || (bp_m == 2'h2 && a >= 16'h8000) || (bp_m == 2'h1 && a >= 16'hC000);
    endfunction

    task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ----------------------------------------
    // operations
    // ----------------------------------------
    task automatic simple(input logic [7:0] op);
        host_u.start();
        host_u.xfer(op, 1'b0, rx);
        host_u.stop();
        if (op == OP_SET_LATCH) wel_m = 1'b1;
        if (op == OP_CLR_LATCH) wel_m = 1'b0;
    endtask

    task automatic stat_rd();
        host_u.start();
        host_u.xfer(OP_STAT_RD, 1'b0, rx);
        host_u.xfer(8'h00, 1'b0, rx);
        check_val("status", stat_m(), rx);
        check_val("oe_on", 8'h01, {7'h0, host_u.oe_seen});
        host_u.stop();
        check_val("oe_off", 8'h00, {7'h0, miso_oe});
    endtask

    task automatic stat_wr(input logic [7:0] d, input logic flip);
        host_u.start();
        host_u.xfer(OP_STAT_WR, 1'b0, rx);
        if (flip) host_u.set_wp(~wp_m);
        host_u.xfer(d, 1'b0, rx);
        host_u.stop();
        // pin level as seen at frame start
        if (wel_m && !(en_m && !wp_m)) {en_m, bp_m} = {d[7], d[3:2]};
        wel_m = 1'b0;
        if (flip) wp_m = ~wp_m;
    endtask

    task automatic mem_wr(input logic [15:0] a, input int n, input logic part);
        logic [7:0] d;
        host_u.start();
        host_u.xfer(OP_WRITE, 1'b0, rx);
        host_u.xfer(a[15:8], 1'b0, rx);
        host_u.xfer(a[7:0], 1'b0, rx);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            host_u.xfer(d, i == 0, rx);
            if (wel_m && !prot_m(a)) mem_m[a] = d;
            a++;
        end
        // partial byte must not land
        if (part) for (int i = 0; i < 4; i++) host_u.bit_io(1'b1, 1'b0, rx[0]);
        host_u.stop();
        check_val("oe_wr", 8'h00, {7'h0, host_u.oe_seen});
        wel_m = 1'b0;
    endtask

    task automatic mem_rd(input logic [7:0] op, input logic [15:0] a, input int n);
        host_u.start();
        host_u.xfer(op, 1'b0, rx);
        host_u.xfer(a[15:8], 1'b0, rx);
        host_u.xfer(a[7:0], 1'b0, rx);
        if (op == OP_FAST_READ) host_u.xfer(8'($urandom), 1'b0, rx);
        for (int i = 0; i < n; i++) begin
            host_u.xfer(8'($urandom), 1'b0, rx);
            check_val("read", mem_m[a], rx);
            a++;
        end
        check_val("oe_rd", 8'h01, {7'h0, host_u.oe_seen});
        host_u.stop();
        check_val("oe_off", 8'h00, {7'h0, miso_oe});
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {clock, rstn} = 2'h0;
        {en_m, wel_m, bp_m, wp_m, fail_count, total_checks} = {PIN_PROTECT_ENABLE_RESET, WEL_RESET, BP_RESET, 1'b1, 64'h0};
        void'($urandom(32'h7CEA5406));
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        // burst through the write queue of the core
        simple(OP_SET_LATCH);
        mem_wr(16'h4000, 6, 1'b0);
        mem_rd(OP_READ, 16'h4000, 6);
        stat_rd();
        simple(OP_SET_LATCH);
        stat_rd();
        simple(OP_CLR_LATCH);
        stat_rd();
        // unknown opcode, then a second opcode in the same frame
        host_u.start();
        host_u.xfer(8'hA5, 1'b0, rx);
        host_u.xfer(OP_SET_LATCH, 1'b0, rx);
        host_u.stop();
        check_val("oe_seen", 8'h00, {7'h0, host_u.oe_seen});
        stat_rd();
        simple(OP_SET_LATCH);
        mem_wr(16'hFFFE, 4, 1'b0);
        stat_rd();
        mem_rd(OP_READ, 16'hFFFE, 4);
        mem_rd(OP_FAST_READ, 16'hFFFF, 3);
        mem_wr(16'hFFFF, 2, 1'b0);
        mem_rd(OP_READ, 16'hFFFF, 2);
        simple(OP_SET_LATCH);
        mem_wr(16'h0000, 1, 1'b1);
        mem_rd(OP_READ, 16'h0000, 2);
        host_u.set_wp(1'b0);
        wp_m = 1'b0;
        for (int bp = 0; bp < 4; bp++) begin
            simple(OP_SET_LATCH);
            stat_wr({4'h3, 2'(bp), 2'h3}, 1'b0);
            stat_rd();
            foreach (addrs[k]) begin
                simple(OP_SET_LATCH);
                mem_wr(addrs[k], 1, 1'b0);
                mem_rd(OP_READ, addrs[k], 1);
            end
        end
        rstn <= 1'b0;
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        {en_m, wel_m, wp_m} = {PIN_PROTECT_ENABLE_RESET, WEL_RESET, 1'b0};
        stat_rd();
        host_u.set_wp(1'b1);
        wp_m = 1'b1;
        simple(OP_SET_LATCH);
        stat_wr(8'h80, 1'b0);
        stat_rd();
        host_u.set_wp(1'b0);
        wp_m = 1'b0;
        simple(OP_SET_LATCH);
        stat_wr(8'h8C, 1'b1);
        stat_rd();
        simple(OP_SET_LATCH);
        stat_wr(8'h00, 1'b0);
        stat_rd();
        test_done();
    end

    initial begin
        repeat (90000) @(posedge clock);
        fail_count++;
        test_done();
    end
endmodule

// ### tb/sfpa_host.sv
module sfpa_host
    import sfpa_pkg::*;
(
    input  wire logic clock,
    input  wire logic miso,
    input  wire logic miso_oe,
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    output logic      hold_n,
    output logic      wp_n
);
    timeunit 1ns;
    timeprecision 1ps;

    logic last_reg;
    logic line;
    logic oe_seen;

    // released line shows the inverse of the last bit, never a stale copy
    always @(posedge clock) if (miso_oe === 1'b1) last_reg <= miso;
    assign line = miso_oe ? miso : ~last_reg;

    initial begin
        {sclk, mosi, last_reg, oe_seen} = 4'h0;
        {cs_n, hold_n, wp_n} = 3'h7;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock);
    endtask

    // ----------------------------------------
    // bus cycles
    // ----------------------------------------
    // one opcode per frame
    task automatic start();
        oe_seen = 1'b0;
        @(posedge clock);
        cs_n <= 1'b0;
        wait_clk(4);
    endtask

    task automatic stop();
        @(posedge clock);
        cs_n <= 1'b1;
        wait_clk(8);
    endtask

    task automatic set_wp(input logic v);
        @(posedge clock);
        wp_n <= v;
    endtask

    task automatic bit_io(input logic b, input logic pause, output logic r);
        @(posedge clock);
        sclk <= 1'b0;
        mosi <= b;
        if (pause) begin
            // pause moved only with clock low; clock toggles meanwhile
            wait_clk(3);
            hold_n <= 1'b0;
            wait_clk(3);
            sclk <= 1'b1;
            wait_clk(6);
            sclk <= 1'b0;
            wait_clk(6);
            hold_n <= 1'b1;
        end
        wait_clk(6);
        // sample on rising clock, msb first
        r = line;
        if (miso_oe === 1'b1) oe_seen = 1'b1;
        sclk <= 1'b1;
        wait_clk(5);
    endtask

    task automatic xfer(input logic [7:0] tx, input logic pause, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], pause && i == 3, rx[i]);
    endtask
endmodule
